/* File: bpm_core_model.sv */
// core-side model: issues fetch, data and io accesses and trap instructions
`timescale 1ns/10ps
module bpm_core_model (
    input  wire        pclk,
    output reg         acc_valid,
    output reg  [1:0]  acc_kind,
    output reg  [63:0] acc_addr,
    output reg  [3:0]  acc_size,
    output reg         hw_debug_trap_instr,
    output reg         sw_breakpoint_instr
);
    // quiet pipeline at start
    initial begin
        acc_valid = 1'b0;
        acc_kind = 2'h0;
        acc_addr = 64'h0;
        acc_size = 4'h1;
        hw_debug_trap_instr = 1'b0;
        sw_breakpoint_instr = 1'b0;
    end
    // one access for one cycle; afterwards the address lines are scrambled
    task issue(input v, input [1:0] k, input [63:0] a, input [3:0] s, input t1, input t3);
        begin
            acc_valid <= v;
            acc_kind <= k;
            acc_addr <= a;
            acc_size <= s;
            hw_debug_trap_instr <= t1;
            sw_breakpoint_instr <= t3;
            @(posedge pclk);
            acc_valid <= 1'b0;
            hw_debug_trap_instr <= 1'b0;
            sw_breakpoint_instr <= 1'b0;
            acc_addr <= ~a;
        end
    endtask
endmodule // bpm_core_model

/* File: bpm_defines.vh */
// constants for the breakpoint match unit
`ifndef BPM_DEFINES_VH
`define BPM_DEFINES_VH
// apb byte offsets: address regs take a low and a high word each
`define BPM_OFF_ADDR0_LO 8'h00
`define BPM_OFF_ADDR3_HI 8'h1c
`define BPM_OFF_STAT_LO  8'h20
`define BPM_OFF_STAT_HI  8'h24
`define BPM_OFF_CTRL_LO  8'h28
`define BPM_OFF_CTRL_HI  8'h2c
`define BPM_OFF_MODE     8'h30
// reset values
`define BPM_RST_STAT     32'h0001_0800
`define BPM_RST_CTRL     32'h0000_0000
`define BPM_RST_MODE     2'h0
// field positions
`define BPM_STAT_ACC_BIT 13
`define BPM_CTRL_PROT_BIT 13
`define BPM_CTRL_COND_LSB 16
`define BPM_MODE_LONG_BIT 0
`define BPM_MODE_EXT_BIT 1
// condition codes
`define BPM_COND_EXEC    2'h0
`define BPM_COND_WRITE   2'h1
`define BPM_COND_IO      2'h2
`define BPM_COND_RDWR    2'h3
// length codes
`define BPM_LEN_1        2'h0
`define BPM_LEN_2        2'h1
`define BPM_LEN_8        2'h2
`define BPM_LEN_4        2'h3
// access kinds from the core
`define BPM_KIND_FETCH   2'h0
`define BPM_KIND_WRITE   2'h1
`define BPM_KIND_IO      2'h2
`define BPM_KIND_READ    2'h3
// exception vectors
`define BPM_VEC_DEBUG    8'h01
`define BPM_VEC_BREAK    8'h03
`endif

/* File: bpm_unit.v */
// breakpoint match unit: debug registers on apb, range compare, exception classing
//
// Behaviour
// - four ranges of 1, 2, 4, 8 bytes
// - length code 00/01/11/10 gives 1/2/4/8
// - condition selects exec, write, io, read-write
// - length masks low breakpoint address bits
// - io addresses zero-extended from 16 bits
// - any touched byte in range matches
// - byte breakpoints never hit neighbouring bytes
// - exec matches only the first instruction byte
// - 64-bit regs, narrow mode zeroes upper half
// - long mode moves all 64 bits
// - nonzero long-mode writes to reserved upper status/control words raise protection fault when protection is off
// - address regs fully writable, no limit check
// - eight-byte ranges supported in every mode
// - debug on vector 1, breakpoint on 3
// - exec and protect are faults, others traps
// - one report may carry fault and trap
// - hit sets status only in a cycle that raises an exception, enable gates exception
// - access under protection sets flag, faults
// - hardware trap instruction traps, no flags
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "bpm_defines.vh"

// register map, byte offsets on the apb side
//   0x00 + 8n : breakpoint n address, low word
//   0x04 + 8n : breakpoint n address, high word
//   0x20      : status, low word
//   0x24      : status, high word (reserved)
//   0x28      : control, low word
//   0x2c      : control, high word (reserved)
//   0x30      : mode, bit0 long mode, bit1 debug extension
//
// control layout
//   bits 0..7   : local and global enable per breakpoint
//   bit 13      : debug register protection
//   bits 16..31 : condition and length, four bits per breakpoint
//
// status layout
//   bits 0..3   : raw hit flags, one per breakpoint
//   bit 13      : protected access seen
//   bits 11, 16 : read as one after reset
//
// apb timing
//   - zero wait states, pready is tied high
//   - read data is taken at the setup edge and stands
//     through the access phase
//   - writes land at the access edge
//   - pslverr only shows during the access phase
//
// refused transfers
//   - unmapped or unaligned offsets: error, no write
//   - any debug register while protection is on: error,
//     no write, read as zero, access flag set, fault raised
//   - long mode, protection off, nonzero write to a reserved upper word:
//     error plus a protection fault pulse
//
// core side timing
//   - each cycle with acc_valid high is one access
//   - all four comparators look at it in that same cycle
//   - exception outputs pulse one edge later for one cycle
//   - fault and trap may pulse together in one report
//
// matching
//   - data and io use the masked base up to base or mask,
//     so a misaligned base still gives an aligned range
//   - an access hits if any touched byte lies in the range
//   - fetch uses exact equality with the stored address,
//     the length field is not looked at for fetches
//   - io condition matches only with the extension bit on
//
// hazards worth knowing
//   - hit flags update only in a cycle that raises an
//     exception; they then show every raw hit, enabled or not
//   - a hardware hit beats a same-cycle software status write
//   - protection drops on any debug exception, also when a
//     control write lands in that same cycle
//   - the mode register is never protected, so software can
//     always leave long mode
//   - addresses are not checked against any address limit

module bpm_unit #(
    parameter NUM_BP = 4
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        acc_valid,
    input  wire [1:0]  acc_kind,
    input  wire [63:0] acc_addr,
    input  wire [3:0]  acc_size,
    input  wire        hw_debug_trap_instr,
    input  wire        sw_breakpoint_instr,
    output reg         debug_exception,
    output reg         breakpoint_exception,
    output reg         exc_fault,
    output reg         exc_trap,
    output reg  [7:0]  exc_vector,
    output reg         general_protection_fault
);

    // storage
    reg  [63:0] bp_addr_reg [0:3];      // breakpoint addresses
    reg  [31:0] debug_status_reg;       // sticky status
    reg  [31:0] debug_control_reg;      // enables, conditions, lengths
    reg  [1:0]  mode_reg;               // long mode, debug extension

    wire        long_mode         = mode_reg[`BPM_MODE_LONG_BIT];
    wire        debug_ext_control = mode_reg[`BPM_MODE_EXT_BIT];
    wire        dbgreg_protect_enable = debug_control_reg[`BPM_CTRL_PROT_BIT];

    // apb decode
    wire        apb_setup   = psel & ~penable;
    wire        apb_access  = psel & penable;
    wire        in_addr     = (paddr <= `BPM_OFF_ADDR3_HI);
    wire        mapped      = in_addr | (paddr == `BPM_OFF_STAT_LO) | (paddr == `BPM_OFF_STAT_HI)
                              | (paddr == `BPM_OFF_CTRL_LO) | (paddr == `BPM_OFF_CTRL_HI)
                              | (paddr == `BPM_OFF_MODE);
    wire        word_ok     = (paddr[1:0] == 2'h0);
    wire        is_dbgreg   = mapped & word_ok & (paddr != `BPM_OFF_MODE);
    // protected access: debug regs locked while protection is on
    wire        prot_hit    = apb_access & is_dbgreg & dbgreg_protect_enable;
    // reserved upper halves of status/control in long mode
    wire        resv_hi     = (paddr == `BPM_OFF_STAT_HI) | (paddr == `BPM_OFF_CTRL_HI);
    wire        gp_hit      = apb_access & pwrite & ~dbgreg_protect_enable & long_mode
                              & resv_hi & (pwdata != 32'h0);
    wire        bad_addr    = ~(mapped & word_ok);
    wire        wr_ok       = apb_access & pwrite & ~bad_addr & ~prot_hit & ~gp_hit;

    assign pready  = 1'b1;                                  // zero wait states
    assign pslverr = apb_access & (bad_addr | prot_hit | gp_hit);

    // per-breakpoint fields
    wire [NUM_BP-1:0] bp_en;
    wire [NUM_BP-1:0] bp_hit;
    wire [NUM_BP-1:0] bp_exec_hit;

    // io port address widened with zeros before compare
    wire [63:0] eff_addr  = (acc_kind == `BPM_KIND_IO) ? {48'h0, acc_addr[15:0]} : acc_addr;
    wire [63:0] eff_last  = eff_addr + {60'h0, acc_size} - 64'h1;

    genvar g;
    generate
        for (g = 0; g < NUM_BP; g = g + 1) begin : g_bp
            wire        bp_local_enable  = debug_control_reg[2*g];
            wire        bp_global_enable = debug_control_reg[2*g+1];
            wire [1:0]  bp_condition_field = debug_control_reg[`BPM_CTRL_COND_LSB+4*g +: 2];
            wire [1:0]  bp_length_field    = debug_control_reg[`BPM_CTRL_COND_LSB+4*g+2 +: 2];
            reg  [63:0] len_mask;
            wire [63:0] base;
            wire [63:0] top;
            wire        overlap;
            reg         kind_ok;
            // length code to low-bit mask
            always @* begin
                case (bp_length_field)
                    `BPM_LEN_1: len_mask = 64'h0;
                    `BPM_LEN_2: len_mask = 64'h1;
                    `BPM_LEN_4: len_mask = 64'h3;
                    `BPM_LEN_8: len_mask = 64'h7;
                    default:    len_mask = 64'h0;
                endcase
            end
            // aligned range start and end
            assign base    = bp_addr_reg[g] & ~len_mask;
            assign top     = base | len_mask;
            // any byte of the access inside the range, other bytes may lie beyond it
            assign overlap = (eff_addr <= top) & (base <= eff_last);
            // condition against access kind
            always @* begin
                case (bp_condition_field)
                    `BPM_COND_EXEC:  kind_ok = (acc_kind == `BPM_KIND_FETCH);
                    `BPM_COND_WRITE: kind_ok = (acc_kind == `BPM_KIND_WRITE);
                    `BPM_COND_IO:    kind_ok = (acc_kind == `BPM_KIND_IO) & debug_ext_control;
                    `BPM_COND_RDWR:  kind_ok = (acc_kind == `BPM_KIND_WRITE) | (acc_kind == `BPM_KIND_READ);
                    default:         kind_ok = 1'b0;
                endcase
            end
            assign bp_en[g]       = bp_local_enable | bp_global_enable;
            // fetch hits only at the first byte of the instruction
            assign bp_exec_hit[g] = acc_valid & kind_ok & (bp_condition_field == `BPM_COND_EXEC)
                                    & (eff_addr == bp_addr_reg[g]);
            assign bp_hit[g]      = bp_exec_hit[g] | (acc_valid & kind_ok
                                    & (bp_condition_field != `BPM_COND_EXEC) & overlap);
        end
    endgenerate

    // classification of this cycle's events
    wire [NUM_BP-1:0] en_hit   = bp_hit & bp_en;
    wire        fault_evt = (|(en_hit & bp_exec_hit)) | prot_hit;
    wire        trap_evt  = (|(en_hit & ~bp_exec_hit)) | hw_debug_trap_instr;
    wire        dbg_evt   = fault_evt | trap_evt;

    // exception outputs, one-cycle pulses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_exception          <= 1'b0;
            breakpoint_exception     <= 1'b0;
            exc_fault                <= 1'b0;
            exc_trap                 <= 1'b0;
            exc_vector               <= 8'h0;
            general_protection_fault <= 1'b0;
        end else begin
            debug_exception          <= dbg_evt;
            breakpoint_exception     <= sw_breakpoint_instr;
            exc_fault                <= fault_evt;
            exc_trap                 <= trap_evt;
            general_protection_fault <= gp_hit;
            if (dbg_evt) begin
                exc_vector <= `BPM_VEC_DEBUG;
            end else if (sw_breakpoint_instr) begin
                exc_vector <= `BPM_VEC_BREAK;
            end else begin
                exc_vector <= 8'h0;
            end
        end
    end

    // next status: software write first, hardware sets on top so a set wins
    reg [31:0] next_status;
    always @* begin
        next_status = debug_status_reg;
        if (wr_ok && paddr == `BPM_OFF_STAT_LO) begin
            next_status = pwdata;
        end
        // hit flags update only when an exception is raised
        if (fault_evt | (|en_hit)) begin
            next_status[NUM_BP-1:0] = next_status[NUM_BP-1:0] | bp_hit;
        end
        if (prot_hit) begin
            next_status[`BPM_STAT_ACC_BIT] = 1'b1;
        end
    end

    // register writes
    integer i;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < NUM_BP; i = i + 1) begin
                bp_addr_reg[i] <= 64'h0;
            end
            debug_status_reg  <= `BPM_RST_STAT;
            debug_control_reg <= `BPM_RST_CTRL;
            mode_reg          <= `BPM_RST_MODE;
        end else begin
            debug_status_reg <= next_status;
            // address words, no limit check on the value
            if (wr_ok && in_addr) begin
                if (!paddr[2]) begin
                    bp_addr_reg[paddr[4:3]][31:0] <= pwdata;
                    if (!long_mode) begin
                        bp_addr_reg[paddr[4:3]][63:32] <= 32'h0;
                    end
                end else if (long_mode) begin
                    bp_addr_reg[paddr[4:3]][63:32] <= pwdata;
                end
            end
            // software write first, then protection drops as the handler is entered
            if (wr_ok && paddr == `BPM_OFF_CTRL_LO) begin
                debug_control_reg <= pwdata;
            end
            if (dbg_evt) begin
                debug_control_reg[`BPM_CTRL_PROT_BIT] <= 1'b0;
            end
            if (wr_ok && paddr == `BPM_OFF_MODE) begin
                mode_reg <= pwdata[1:0];
            end
        end
    end

    // read data captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (apb_setup && !pwrite) begin
            if (is_dbgreg && dbgreg_protect_enable) begin
                // locked registers read as zero
                prdata <= 32'h0;
            end else if (in_addr && word_ok) begin
                // upper half reads as zero outside long mode
                prdata <= paddr[2] ? (long_mode ? bp_addr_reg[paddr[4:3]][63:32] : 32'h0)
                                   : bp_addr_reg[paddr[4:3]][31:0];
            end else if (paddr == `BPM_OFF_STAT_LO) begin
                prdata <= debug_status_reg;
            end else if (paddr == `BPM_OFF_CTRL_LO) begin
                prdata <= debug_control_reg;
            end else if (paddr == `BPM_OFF_MODE) begin
                prdata <= {30'h0, mode_reg};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

endmodule // bpm_unit

/* File: bpm_unit_sva.sv */
// assertions watching the ports of the breakpoint match unit
`timescale 1ns/10ps
`include "bpm_defines.vh"
module bpm_unit_sva (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire        pslverr,
    input wire        acc_valid,
    input wire [1:0]  acc_kind,
    input wire        hw_debug_trap_instr,
    input wire        sw_breakpoint_instr,
    input wire        debug_exception,
    input wire        breakpoint_exception,
    input wire        exc_fault,
    input wire        exc_trap,
    input wire [7:0]  exc_vector,
    input wire        general_protection_fault
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_hw_trap_class: assert property (hw_debug_trap_instr |=> debug_exception && exc_trap)
        else $error("hardware trap not reported as trap");
    a_sw_break_out: assert property (sw_breakpoint_instr |=> breakpoint_exception)
        else $error("software breakpoint not reported");
    a_debug_vec: assert property (debug_exception |-> exc_vector == `BPM_VEC_DEBUG)
        else $error("debug exception on wrong vector");
    a_break_vec: assert property (breakpoint_exception && !debug_exception |-> exc_vector == `BPM_VEC_BREAK)
        else $error("breakpoint exception on wrong vector");
    a_class_debug: assert property (exc_fault || exc_trap |-> debug_exception)
        else $error("class without debug exception");
    a_fault_cause: assert property (exc_fault |-> $past(acc_valid && acc_kind == `BPM_KIND_FETCH || psel && penable))
        else $error("fault without fetch or register access");
    a_trap_cause: assert property (exc_trap |-> $past(acc_valid && acc_kind != `BPM_KIND_FETCH || hw_debug_trap_instr))
        else $error("trap without data access or trap instruction");
    a_gp_cause: assert property (general_protection_fault |-> $past(pslverr && pwrite && pwdata != 32'h0
        && (paddr == `BPM_OFF_STAT_HI || paddr == `BPM_OFF_CTRL_HI)))
        else $error("protection fault without reserved write");
    a_idle_quiet: assert property (!acc_valid && !hw_debug_trap_instr && !sw_breakpoint_instr
        && !(psel && penable) |=> !debug_exception && !breakpoint_exception)
        else $error("exception without cause");
endmodule // bpm_unit_sva

/* File: test_bpm_unit.sv */
// self-checking bench for the breakpoint match unit
`timescale 1ns/10ps
`include "bpm_defines.vh"
module test_bpm_unit;
    reg         pclk = 1'b0;    // 10 MHz clock
    reg         presetn = 1'b0; // async reset, active low
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire        pready, pslverr, acc_valid, hw_debug_trap_instr, sw_breakpoint_instr;
    wire        debug_exception, breakpoint_exception, exc_fault, exc_trap, general_protection_fault;
    wire [1:0]  acc_kind;
    wire [63:0] acc_addr;
    wire [3:0]  acc_size;
    wire [7:0]  exc_vector;
    integer     failures = 0;
    integer     num_checks = 0;
    integer     gp_seen = 0;    // protection fault pulses seen
    localparam [1:0] k_fe = `BPM_KIND_FETCH, k_wr = `BPM_KIND_WRITE, k_io = `BPM_KIND_IO, k_rd = `BPM_KIND_READ;
    always #50 pclk = ~pclk;
    // count protection fault pulses
    always @(posedge pclk) if (general_protection_fault === 1'b1) gp_seen <= gp_seen + 1;
    bpm_unit u_bpm_unit (.*);
    bpm_core_model u_bpm_core_model (.*);
    task wrap_up;
        begin
            if (failures == 0 && num_checks > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task check(input ok, input string m);
        begin
            num_checks = num_checks + 1;
            if (ok !== 1'b1) begin
                failures = failures + 1;
                $display("ERROR %0t %s", $time, m);
            end
        end
    endtask
    // one apb transfer: expected error flag e, expected read data x
    task apb(input w, input [7:0] a, input [31:0] d, input e, input [31:0] x);
        integer n;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin @(posedge pclk); n = n + 1; end while (pready !== 1'b1 && n < 20);
            check(pready === 1'b1, "apb no ready");
            check(pslverr === e && (w || prdata === x), "apb response");
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    // one core access, then compare exception outputs one edge later
    task acc(input v, input [1:0] k, input [63:0] a, input [3:0] s, input t1, input t3, input f, input t);
        begin
            u_bpm_core_model.issue(v, k, a, s, t1, t3);
            #1;
            check(debug_exception === (f | t) && exc_fault === f && exc_trap === t && breakpoint_exception === t3
                && exc_vector === ((f | t) ? `BPM_VEC_DEBUG : t3 ? `BPM_VEC_BREAK : 8'h00), "exception outputs");
            @(posedge pclk);
        end
    endtask
    task t_reset;
        begin
            apb(0, `BPM_OFF_STAT_LO, 0, 0, `BPM_RST_STAT);
            apb(0, `BPM_OFF_CTRL_LO, 0, 0, `BPM_RST_CTRL);
            apb(0, 8'h31, 0, 1, 32'h0);
        end
    endtask
    // four ranges of mixed length and condition, aligned by software
    task t_table;
        begin
            apb(1, 8'h00, 32'h000a_0001, 0, 0);
            apb(1, 8'h08, 32'h000a_0002, 0, 0);
            apb(1, 8'h10, 32'h000b_0002, 0, 0);
            apb(1, 8'h18, 32'h000c_0000, 0, 0);
            apb(1, `BPM_OFF_CTRL_LO, 32'hd713_0055, 0, 0);
            acc(1, k_rd, 64'ha0001, 1, 0, 0, 0, 1);
            acc(1, k_wr, 64'ha0001, 2, 0, 0, 0, 1);
            acc(1, k_wr, 64'ha0002, 1, 0, 0, 0, 1);
            acc(1, k_wr, 64'ha0002, 2, 0, 0, 0, 1);
            acc(1, k_rd, 64'hb0001, 4, 0, 0, 0, 1);
            acc(1, k_wr, 64'hb0002, 1, 0, 0, 0, 1);
            acc(1, k_rd, 64'hb0002, 2, 0, 0, 0, 1);
            acc(1, k_wr, 64'hc0000, 4, 0, 0, 0, 1);
            acc(1, k_wr, 64'hc0001, 2, 0, 0, 0, 1);
            acc(1, k_wr, 64'hc0003, 1, 0, 0, 0, 1);
            acc(1, k_wr, 64'ha0000, 1, 0, 0, 0, 0);
            acc(1, k_rd, 64'ha0002, 1, 0, 0, 0, 0);
            acc(1, k_rd, 64'ha0003, 4, 0, 0, 0, 0);
            acc(1, k_wr, 64'hb0000, 2, 0, 0, 0, 0);
            acc(1, k_rd, 64'hc0000, 2, 0, 0, 0, 0);
            acc(1, k_rd, 64'hc0004, 4, 0, 0, 0, 0);
            apb(0, `BPM_OFF_STAT_LO, 0, 0, 32'h0001_080f);
            apb(1, `BPM_OFF_CTRL_LO, 32'hd713_0000, 0, 0);
            acc(1, k_rd, 64'ha0001, 1, 0, 0, 0, 0);
        end
    endtask
    // io range with extension on, exec range with length 00
    task t_exec_io;
        begin
            apb(1, `BPM_OFF_MODE, 32'h2, 0, 0);
            apb(1, 8'h00, 32'h0000_1234, 0, 0);
            apb(1, 8'h08, 32'h0000_8000, 0, 0);
            apb(1, `BPM_OFF_CTRL_LO, 32'h0002_0005, 0, 0);
            acc(1, k_io, 64'hffff_ffff_ffff_1234, 1, 0, 0, 0, 1);
            acc(1, k_io, 64'h1235, 1, 0, 0, 0, 0);
            acc(1, k_fe, 64'h8000, 1, 0, 0, 1, 0);
            acc(1, k_fe, 64'h8001, 1, 0, 0, 0, 0);
            acc(1, k_fe, 64'h8000, 1, 1, 0, 1, 1);
        end
    endtask
    task t_traps;
        begin
            apb(1, `BPM_OFF_STAT_LO, `BPM_RST_STAT, 0, 0);
            acc(0, k_fe, 64'h0, 1, 1, 0, 0, 1);
            acc(0, k_fe, 64'h0, 1, 0, 1, 0, 0);
            apb(0, `BPM_OFF_STAT_LO, 0, 0, `BPM_RST_STAT);
        end
    endtask
    task t_protect;
        begin
            apb(1, `BPM_OFF_CTRL_LO, 32'h0000_2000, 0, 0);
            apb(0, `BPM_OFF_STAT_LO, 0, 1, 0);
            apb(0, `BPM_OFF_STAT_LO, 0, 0, 32'h0001_2800);
            apb(0, `BPM_OFF_CTRL_LO, 0, 0, 32'h0);
        end
    endtask
    // long mode halves, reserved bits, narrow-mode eight-byte range
    task t_wide;
        begin
            apb(1, `BPM_OFF_MODE, 32'h1, 0, 0);
            apb(1, `BPM_OFF_CTRL_HI, 32'h1, 1, 0);
            apb(1, 8'h04, 32'hdead_beef, 0, 0);
            check(gp_seen === 1, "protection fault pulse count");
            apb(0, 8'h04, 0, 0, 32'hdead_beef);
            apb(1, `BPM_OFF_MODE, 32'h0, 0, 0);
            apb(1, 8'h00, 32'h0000_0013, 0, 0);
            apb(1, `BPM_OFF_CTRL_LO, 32'h000b_0001, 0, 0);
            acc(1, k_rd, 64'h10, 1, 0, 0, 0, 1);
            acc(1, k_wr, 64'h18, 1, 0, 0, 0, 0);
            apb(1, `BPM_OFF_MODE, 32'h1, 0, 0);
            apb(0, 8'h04, 0, 0, 32'h0);
        end
    endtask
    // watchdog cuts a hang short
    initial begin
        #200000;
        failures = failures + 1;
        wrap_up;
    end
    // reset, then every scenario in turn
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_table;
        t_exec_io;
        t_traps;
        t_protect;
        t_wide;
        wrap_up;
    end
endmodule // test_bpm_unit
bind bpm_unit bpm_unit_sva u_bpm_unit_sva (.*);
